// ===== rtl/rsc_pkg.sv
// Shared constants and types of the radio command decoder and its host.
// Assumes one system clock shared by both ends; nothing is imported.
package rsc_pkg;
  // Single-byte radio command codes.
  localparam logic [7:0] SYNC_COMMAND = 8'hA2;
  localparam logic [7:0] OFF_COMMAND = 8'hB0;
  localparam logic [7:0] ON_COMMAND = 8'hB1;
  localparam logic [7:0] RECEIVE_COMMAND = 8'hB2;
  localparam logic [7:0] TRANSMIT_COMMAND = 8'hB5;
  localparam logic [7:0] SLEEP_COMMAND = 8'hBA;
  localparam logic [7:0] APPLY_CONFIG_COMMAND = 8'hBB;
  localparam logic [7:0] SIGNAL_LEVEL_COMMAND = 8'hBC;
  localparam logic [7:0] IMAGE_CAL_COMMAND = 8'hBD;
  localparam logic [7:0] IF_FILTER_CAL_COMMAND = 8'hBE;
  localparam logic [7:0] LOAD_PREP_COMMAND = 8'hBF;
  localparam logic [7:0] LOAD_DONE_COMMAND = 8'hC7;
  localparam logic [7:0] FULL_RESET_COMMAND = 8'hC8;
  localparam logic [7:0] ENCRYPT_COMMAND = 8'hD0;
  localparam logic [7:0] DECRYPT_PREP_COMMAND = 8'hD1;
  localparam logic [7:0] DECRYPT_COMMAND = 8'hD2;
  localparam logic [7:0] NO_OPERATION_BYTE = 8'hFF;
  // Memory access prefixes; the low three command bits are address bits 10:8.
  localparam logic [4:0] SEQ_WRITE_PREFIX = 5'h03;
  localparam logic [4:0] SEQ_READ_PREFIX = 5'h07;
  localparam logic [4:0] RANDOM_WRITE_PREFIX = 5'h01;
  localparam logic [4:0] RANDOM_READ_PREFIX = 5'h05;
  // Memory spaces as seen in address bits 10:8.
  localparam logic [2:0] PACKET_SPACE = 3'h0;
  localparam logic [2:0] BATTERY_BACKED_SPACE = 3'h1;
  localparam logic [2:0] MODEM_CONFIG_SPACE = 3'h3;
  localparam logic [2:0] PROGRAM_SPACE = 3'h6;
  // Registers held inside the decoder.
  localparam logic [10:0] RADIO_OPTION_BITS_ADDR = 11'h11A;
  localparam logic [10:0] FRONT_END_PIN_SELECT_ADDR = 11'h139;
  localparam logic [7:0] RADIO_OPTION_BITS_RST = 8'h00;
  localparam logic [7:0] FRONT_END_PIN_SELECT_RST = 8'h00;
  localparam int EXT_AMP_TX_ENABLE_BIT = 0;
  localparam int EXT_AMP_RX_ENABLE_BIT = 1;
  localparam int PIN_SELECT_BIT = 7;
  // Host register indices and serial clock timing.
  localparam logic [1:0] HOST_DATA_REG = 2'h0;
  localparam logic [1:0] HOST_CTRL_REG = 2'h1;
  localparam logic [1:0] HOST_STATUS_REG = 2'h2;
  localparam logic [1:0] HOST_DIV_REG = 2'h3;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_HALF_NS = 64;
  localparam logic [7:0] HOST_DIV_RST = 8'(SCLK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] HOST_DIV_MIN = 8'h06;

  typedef enum logic [2:0] {
    off_state = 3'b000,
    on_state = 3'b001,
    receive_state = 3'b010,
    transmit_state = 3'b011,
    sleep_state = 3'b100
  } rsc_radio_t;

  typedef enum logic [3:0] {
    ACT_NONE = 4'b0000,
    ACT_SYNC = 4'b0001,
    ACT_APPLY_CONFIG = 4'b0010,
    ACT_SIGNAL_LEVEL = 4'b0011,
    ACT_IF_FILTER_CAL = 4'b0100,
    ACT_FULL_RESET = 4'b0101,
    ACT_LOAD_PREP = 4'b0110,
    ACT_CPU_RESET = 4'b0111,
    ACT_IMAGE_CAL = 4'b1000,
    ACT_ENCRYPT = 4'b1001,
    ACT_DECRYPT_PREP = 4'b1010,
    ACT_DECRYPT = 4'b1011,
    ACT_FEC_ENCODE_PREP = 4'b1100,
    ACT_FEC_ENCODE = 4'b1101,
    ACT_FEC_DECODE = 4'b1110
  } rsc_act_t;
endpackage : rsc_pkg

// ===== rtl/rsc_spi_if.sv
// Serial link and interrupt pin between the host and the decoder.
// Assumes the testbench instantiates it once and joins both ends.
`timescale 1ns/10ps
interface rsc_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic irq;
  modport host (output sclk, output cs_n, output mosi, input miso, input irq);
  modport dev (input sclk, input cs_n, input mosi, output miso, output irq);
endinterface : rsc_spi_if

// ===== rtl/rsc_dev.sv
// Device end: serial command interpreter, memory access port, radio state
// and external amplifier controls.
// Assumes a host on the link whose serial clock half period is at least six
// system clocks, and a memory that answers a read one cycle after the strobe.
`timescale 1ns/10ps
module rsc_dev (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  rsc_spi_if.dev spi, // Link to the host.
  input wire logic i_fw_image_cal, // Image calibration module loaded.
  input wire logic i_fw_cipher, // Cipher module loaded.
  input wire logic i_fw_coding, // Error correction module loaded.
  input wire logic i_event, // Event level for the interrupt pin.
  input wire logic [7:0] i_mem_rdata, // Memory read data.
  output rsc_pkg::rsc_radio_t o_state, // Radio state.
  output logic o_act_valid, // One-cycle action pulse.
  output rsc_pkg::rsc_act_t o_act, // Action code.
  output logic o_mem_wr, // Memory write strobe.
  output logic o_mem_rd, // Memory read strobe.
  output logic [10:0] o_mem_addr, // Memory address.
  output logic [7:0] o_mem_wdata, // Memory write data.
  output logic o_test_pin_a, // Transmit amp control, low-voltage pins.
  output logic o_test_pin_b, // Receive amp control, low-voltage pins.
  output logic o_test_oe, // Test pins driven.
  output logic o_crystal_pin_p, // Transmit amp control, supply pins.
  output logic o_crystal_pin_n, // Receive amp control, supply pins.
  output logic o_crystal_oe // Crystal pins driven.
);
  typedef enum logic [1:0] {
    ST_CMD = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_SKIP = 2'b11
  } rsc_dec_t;
  typedef enum logic [1:0] {
    OP_SEQ_WR = 2'b00,
    OP_SEQ_RD = 2'b01,
    OP_RND_WR = 2'b10,
    OP_RND_RD = 2'b11
  } rsc_op_t;

  logic [2:0] pin1_q, pin2_q, pin3_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_q;
  logic [7:0] rx_byte, tx_q, opt_q, sel_q, int_val_q;
  logic rise, fall, cs_open, byte_done, cmd_take, full_reset;
  rsc_dec_t st_q;
  rsc_op_t op_q, op_d;
  logic op_hit, is_rd, do_rd, do_wr, hit_opt, hit_sel, internal;
  logic [2:0] hi_q;
  logic [10:0] addr_q, acc_addr;
  logic rd_pend_q, rd_ack_q, int_sel_q, irq_q;
  rsc_pkg::rsc_radio_t radio_q;
  rsc_pkg::rsc_act_t act_d;

  // Link pins pass two flops; the third stage only serves edge detection.
  always_ff @(posedge i_clk_sys) begin
    pin1_q <= {spi.sclk, spi.cs_n, spi.mosi};
    pin2_q <= pin1_q;
    pin3_q <= pin2_q;
  end

  // Edges are only honoured while the frame is open.
  assign rise = pin2_q[2] & ~pin3_q[2] & ~pin2_q[1];
  assign fall = ~pin2_q[2] & pin3_q[2] & ~pin2_q[1];
  assign cs_open = ~pin2_q[1] & pin3_q[1];
  assign rx_byte = {rx_q, pin2_q[0]};
  assign byte_done = rise & (bit_cnt_q == 3'h7);
  assign cmd_take = byte_done & (st_q == ST_CMD);
  assign full_reset = cmd_take & (rx_byte == rsc_pkg::FULL_RESET_COMMAND);

  // Bits shift in on the rising edge, MSB first; the count restarts per frame.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || pin2_q[1]) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 7'h00;
    end else if (rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_q <= rx_byte[6:0];
    end
  end

  // Memory prefix decode of the first byte of a frame.
  always_comb begin
    op_hit = 1'b1;
    op_d = OP_SEQ_WR;
    case (rx_byte[7:3])
      rsc_pkg::SEQ_WRITE_PREFIX: op_d = OP_SEQ_WR;
      rsc_pkg::SEQ_READ_PREFIX: op_d = OP_SEQ_RD;
      rsc_pkg::RANDOM_WRITE_PREFIX: op_d = OP_RND_WR;
      rsc_pkg::RANDOM_READ_PREFIX: op_d = OP_RND_RD;
      default: op_hit = 1'b0;
    endcase
  end

  // Access address: the space sits in bits 10:8 taken from the command.
  always_comb begin
    is_rd = (op_q == OP_SEQ_RD) || (op_q == OP_RND_RD);
    if (st_q == ST_ADDR) begin
      acc_addr = {hi_q, rx_byte};
    end else if (op_q == OP_SEQ_RD) begin
      acc_addr = addr_q + 11'h001;
    end else begin
      acc_addr = addr_q;
    end
    do_rd = byte_done & (((st_q == ST_ADDR) & is_rd) | ((st_q == ST_DATA) & (op_q == OP_SEQ_RD)));
    do_wr = byte_done & (st_q == ST_DATA) & ~is_rd;
    hit_opt = acc_addr == rsc_pkg::RADIO_OPTION_BITS_ADDR;
    hit_sel = acc_addr == rsc_pkg::FRONT_END_PIN_SELECT_ADDR;
    internal = hit_opt | hit_sel;
  end

  // Frame sequencer; any byte after a radio command is ignored as filler.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= ST_CMD;
      op_q <= OP_SEQ_WR;
      hi_q <= 3'h0;
      addr_q <= 11'h000;
    end else if (cs_open) begin
      st_q <= ST_CMD;
    end else if (byte_done) begin
      case (st_q)
        ST_CMD: begin
          hi_q <= rx_byte[2:0];
          op_q <= op_d;
          st_q <= op_hit ? ST_ADDR : ST_SKIP;
        end
        ST_ADDR: begin
          addr_q <= acc_addr;
          st_q <= ST_DATA;
        end
        ST_DATA: begin
          if (op_q == OP_SEQ_WR || op_q == OP_SEQ_RD) begin
            addr_q <= addr_q + 11'h001;
          end else begin
            st_q <= ST_ADDR;
          end
        end
        default: st_q <= ST_SKIP;
      endcase
    end
  end

  // Memory port; the two internal registers never reach the outside memory.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_mem_wr <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_addr <= 11'h000;
      o_mem_wdata <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_ack_q <= 1'b0;
      int_sel_q <= 1'b0;
      int_val_q <= 8'h00;
    end else begin
      o_mem_wr <= do_wr & ~internal;
      o_mem_rd <= do_rd & ~internal;
      rd_pend_q <= do_rd;
      rd_ack_q <= rd_pend_q;
      if (do_rd || do_wr) begin
        o_mem_addr <= acc_addr;
        o_mem_wdata <= rx_byte;
      end
      if (do_rd) begin
        int_sel_q <= internal;
        int_val_q <= hit_opt ? opt_q : sel_q;
      end
    end
  end

  // Internal registers; a full reset command restores them too.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || full_reset) begin
      opt_q <= rsc_pkg::RADIO_OPTION_BITS_RST;
      sel_q <= rsc_pkg::FRONT_END_PIN_SELECT_RST;
    end else if (do_wr && hit_opt) begin
      opt_q <= rx_byte;
    end else if (do_wr && hit_sel) begin
      sel_q <= rx_byte;
    end
  end

  // Radio state changes on the first byte of a frame only.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      radio_q <= rsc_pkg::sleep_state;
    end else if (cmd_take) begin
      case (rx_byte)
        rsc_pkg::OFF_COMMAND: radio_q <= rsc_pkg::off_state;
        rsc_pkg::ON_COMMAND: radio_q <= rsc_pkg::on_state;
        rsc_pkg::RECEIVE_COMMAND: radio_q <= rsc_pkg::receive_state;
        rsc_pkg::TRANSMIT_COMMAND: radio_q <= rsc_pkg::transmit_state;
        rsc_pkg::SLEEP_COMMAND: radio_q <= rsc_pkg::sleep_state;
        rsc_pkg::FULL_RESET_COMMAND: radio_q <= rsc_pkg::sleep_state;
        default: radio_q <= radio_q;
      endcase
    end
  end
  assign o_state = radio_q;

  // Action decode; module commands do nothing unless their module is loaded.
  // With both the cipher and error correction modules present the cipher meaning is taken.
  always_comb begin
    act_d = rsc_pkg::ACT_NONE;
    case (rx_byte)
      rsc_pkg::SYNC_COMMAND: act_d = rsc_pkg::ACT_SYNC;
      rsc_pkg::APPLY_CONFIG_COMMAND: act_d = rsc_pkg::ACT_APPLY_CONFIG;
      rsc_pkg::SIGNAL_LEVEL_COMMAND: act_d = rsc_pkg::ACT_SIGNAL_LEVEL;
      rsc_pkg::IF_FILTER_CAL_COMMAND: act_d = rsc_pkg::ACT_IF_FILTER_CAL;
      rsc_pkg::FULL_RESET_COMMAND: act_d = rsc_pkg::ACT_FULL_RESET;
      rsc_pkg::LOAD_PREP_COMMAND: act_d = rsc_pkg::ACT_LOAD_PREP;
      rsc_pkg::LOAD_DONE_COMMAND: act_d = rsc_pkg::ACT_CPU_RESET;
      rsc_pkg::IMAGE_CAL_COMMAND: begin
        if (i_fw_image_cal) act_d = rsc_pkg::ACT_IMAGE_CAL;
      end
      rsc_pkg::ENCRYPT_COMMAND: begin
        if (i_fw_cipher) act_d = rsc_pkg::ACT_ENCRYPT;
        else if (i_fw_coding) act_d = rsc_pkg::ACT_FEC_ENCODE;
      end
      rsc_pkg::DECRYPT_PREP_COMMAND: begin
        if (i_fw_cipher) act_d = rsc_pkg::ACT_DECRYPT_PREP;
        else if (i_fw_coding) act_d = rsc_pkg::ACT_FEC_ENCODE_PREP;
      end
      rsc_pkg::DECRYPT_COMMAND: begin
        if (i_fw_cipher) act_d = rsc_pkg::ACT_DECRYPT;
        else if (i_fw_coding) act_d = rsc_pkg::ACT_FEC_DECODE;
      end
      default: act_d = rsc_pkg::ACT_NONE;
    endcase
  end

  // The action pulse lasts one cycle; the code holds until the next one.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_act_valid <= 1'b0;
      o_act <= rsc_pkg::ACT_NONE;
    end else begin
      o_act_valid <= cmd_take & (act_d != rsc_pkg::ACT_NONE);
      if (cmd_take && act_d != rsc_pkg::ACT_NONE) o_act <= act_d;
    end
  end

  // Return path: status on every byte, read data replaces it two cycles on.
  // A status byte reloaded at each boundary lets the host poll with filler.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tx_q <= 8'h00;
    end else if (rd_ack_q) begin
      tx_q <= int_sel_q ? int_val_q : i_mem_rdata;
    end else if (cs_open || byte_done) begin
      tx_q <= {i_fw_coding, i_fw_cipher, i_fw_image_cal, 2'b00, radio_q};
    end else if (fall && bit_cnt_q != 3'h0) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end
  assign spi.miso = tx_q[7];

  // Amplifier controls, routed to one pin pair; the other pair is released.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_test_pin_a <= 1'b0;
      o_test_pin_b <= 1'b0;
      o_test_oe <= 1'b0;
      o_crystal_pin_p <= 1'b0;
      o_crystal_pin_n <= 1'b0;
      o_crystal_oe <= 1'b0;
    end else begin
      o_test_oe <= sel_q[rsc_pkg::PIN_SELECT_BIT];
      o_crystal_oe <= ~sel_q[rsc_pkg::PIN_SELECT_BIT];
      o_test_pin_a <= sel_q[rsc_pkg::PIN_SELECT_BIT] & opt_q[rsc_pkg::EXT_AMP_TX_ENABLE_BIT]
        & (radio_q == rsc_pkg::transmit_state);
      o_test_pin_b <= sel_q[rsc_pkg::PIN_SELECT_BIT] & opt_q[rsc_pkg::EXT_AMP_RX_ENABLE_BIT]
        & (radio_q == rsc_pkg::receive_state);
      o_crystal_pin_p <= ~sel_q[rsc_pkg::PIN_SELECT_BIT]
        & opt_q[rsc_pkg::EXT_AMP_TX_ENABLE_BIT] & (radio_q == rsc_pkg::transmit_state);
      o_crystal_pin_n <= ~sel_q[rsc_pkg::PIN_SELECT_BIT]
        & opt_q[rsc_pkg::EXT_AMP_RX_ENABLE_BIT] & (radio_q == rsc_pkg::receive_state);
    end
  end

  // Events leave on the single interrupt pin, registered.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) irq_q <= 1'b0;
    else irq_q <= i_event;
  end
  assign spi.irq = irq_q;
endmodule : rsc_dev

// ===== rtl/rsc_host.sv
// Host end: byte-wide serial master driven through four small registers.
// Assumes software builds each frame byte by byte and closes it explicitly.
`timescale 1ns/10ps
module rsc_host (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [1:0] i_addr, // Register index.
  input wire logic [7:0] i_wdata, // Write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [7:0] o_rdata, // Read data, cycle after the strobe.
  rsc_spi_if.host spi // Link to the device.
);
  logic [7:0] div_q, cnt_q, txd_q, rxd_q;
  logic [2:0] bits_q;
  logic busy_q, sclk_q, cs_n_q, tick, start;
  logic [1:0] miso_s_q, irq_s_q;

  // Link inputs pass two flops before use.
  always_ff @(posedge i_clk_sys) begin
    miso_s_q <= {miso_s_q[0], spi.miso};
    irq_s_q <= {irq_s_q[0], spi.irq};
  end

  assign tick = busy_q & (cnt_q == 8'h00);
  assign start = i_wr & (i_addr == rsc_pkg::HOST_DATA_REG) & ~busy_q;

  // Divider; a floor keeps the half period long enough for the device.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_q <= rsc_pkg::HOST_DIV_RST;
    end else if (i_wr && i_addr == rsc_pkg::HOST_DIV_REG) begin
      div_q <= (i_wdata < rsc_pkg::HOST_DIV_MIN) ? rsc_pkg::HOST_DIV_MIN : i_wdata;
    end
  end

  // Half-period counter that paces every clock edge.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) cnt_q <= 8'h00;
    else if (start || tick) cnt_q <= div_q - 8'h01;
    else if (busy_q) cnt_q <= cnt_q - 8'h01;
  end

  // Byte engine: sample on the rising edge, shift on the falling edge.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      bits_q <= 3'h0;
      txd_q <= 8'h00;
      rxd_q <= 8'h00;
    end else if (start) begin
      busy_q <= 1'b1;
      bits_q <= 3'h0;
      txd_q <= i_wdata;
    end else if (tick && !sclk_q) begin
      sclk_q <= 1'b1;
      rxd_q <= {rxd_q[6:0], miso_s_q[1]};
    end else if (tick) begin
      sclk_q <= 1'b0;
      txd_q <= {txd_q[6:0], 1'b0};
      bits_q <= bits_q + 3'h1;
      if (bits_q == 3'h7) busy_q <= 1'b0;
    end
  end

  // Chip select opens with a byte and closes only on software order.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) cs_n_q <= 1'b1;
    else if (start) cs_n_q <= 1'b0;
    else if (i_wr && i_addr == rsc_pkg::HOST_CTRL_REG && i_wdata[0] && !busy_q) cs_n_q <= 1'b1;
  end

  // Register read port.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        rsc_pkg::HOST_DATA_REG: o_rdata <= rxd_q;
        rsc_pkg::HOST_STATUS_REG: o_rdata <= {5'h00, irq_s_q[1], ~cs_n_q, busy_q};
        rsc_pkg::HOST_DIV_REG: o_rdata <= div_q;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign spi.sclk = sclk_q;
  assign spi.cs_n = cs_n_q;
  assign spi.mosi = txd_q[7];
endmodule : rsc_host

// ===== bench/rsc_chk_props.sv
// Assertions on the serial link, the interrupt pin and the amp controls.
// Assumes one clock domain; the testbench instantiates it beside the link.
`timescale 1ns/10ps
module rsc_chk_props (
  input wire logic i_clk_sys, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic sclk, // Serial clock.
  input wire logic cs_n, // Frame select.
  input wire logic mosi, // Host data line.
  input wire logic irq, // Interrupt pin.
  input wire logic i_event, // Event level into the device.
  input wire rsc_pkg::rsc_radio_t o_state, // Radio state.
  input wire logic o_test_pin_a, // Transmit amp, test pins.
  input wire logic o_test_pin_b, // Receive amp, test pins.
  input wire logic o_test_oe, // Test pins driven.
  input wire logic o_crystal_pin_p, // Transmit amp, crystal pins.
  input wire logic o_crystal_pin_n, // Receive amp, crystal pins.
  input wire logic o_crystal_oe // Crystal pins driven.
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // The serial clock high half lasts at least the smallest divider, six clocks.
  sequence s_half_high;
    sclk [*6];
  endsequence
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock active outside a frame");
  chk_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("host data changed while serial clock high");
  chk_half_period: assert property ($rose(sclk) |-> s_half_high)
    else $error("serial clock high half too short");
  // Pins follow the state one clock later, so they are tied to the past state.
  chk_tx_amp_state: assert property ((o_test_pin_a || o_crystal_pin_p) |->
    $past(o_state) == rsc_pkg::transmit_state) else $error("transmit amp high off transmit");
  chk_rx_amp_state: assert property ((o_test_pin_b || o_crystal_pin_n) |->
    $past(o_state) == rsc_pkg::receive_state) else $error("receive amp high off receive");
  chk_route_exclusive: assert property (!(o_test_oe && o_crystal_oe))
    else $error("both pin pairs driven");
  chk_test_pins_quiet: assert property (!o_test_oe |-> !o_test_pin_a && !o_test_pin_b)
    else $error("undriven test pins carry a level");
  chk_irq_follows: assert property ($past(i_rst_n) |-> irq == $past(i_event))
    else $error("interrupt pin does not follow the event one clock later");
endmodule : rsc_chk_props

// ===== bench/radio_spi_command_decoder_tb_top.sv
// Self-checking bench: host and decoder joined over the link, memory model.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/10ps
module radio_spi_command_decoder_tb_top;
  logic i_clk_sys, i_rst_n, i_wr, i_rd, i_event, i_mem_rd_unused;
  logic i_fw_image_cal, i_fw_cipher, i_fw_coding;
  logic [1:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_mem_rdata, o_mem_wdata;
  logic [10:0] o_mem_addr;
  rsc_pkg::rsc_radio_t o_state;
  rsc_pkg::rsc_act_t o_act;
  logic o_act_valid, o_mem_wr, o_mem_rd, o_test_pin_a, o_test_pin_b, o_test_oe;
  logic o_crystal_pin_p, o_crystal_pin_n, o_crystal_oe;
  int failures, tests_run;
  logic [19:0] expq[$];
  logic [7:0] mem [2048];
  logic [7:0] tx [8];
  logic [7:0] rx [8];
  logic [7:0] dat [2];
  logic [15:0] lfsr_q;
  logic [7:0] codes [5] = '{8'hB0, 8'hB1, 8'hB2, 8'hB5, 8'hBA};
  logic [2:0] sts [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [2:0] sp [4] = '{3'h0, 3'h1, 3'h3, 3'h6};
  // Action rows: loaded modules, pulse expected, action code, command byte.
  logic [15:0] acts [16] = '{16'h11A2, 16'h12BB, 16'h13BC, 16'h14BE, 16'h16BF, 16'h17C7,
    16'h00BD, 16'h98BD, 16'h59D0, 16'h5AD1, 16'h5BD2, 16'h3DD0, 16'h3CD1, 16'h3ED2,
    16'h00D0, 16'h79D0};
  rsc_spi_if spi ();
  rsc_host rsc_host_inst (.i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .spi(spi));
  rsc_dev rsc_dev_inst (.i_clk_sys, .i_rst_n, .spi(spi), .i_fw_image_cal, .i_fw_cipher,
    .i_fw_coding, .i_event, .i_mem_rdata, .o_state, .o_act_valid, .o_act, .o_mem_wr,
    .o_mem_rd, .o_mem_addr, .o_mem_wdata, .o_test_pin_a, .o_test_pin_b, .o_test_oe,
    .o_crystal_pin_p, .o_crystal_pin_n, .o_crystal_oe);
  rsc_chk_props rsc_chk_props_inst (.i_clk_sys, .i_rst_n, .sclk(spi.sclk), .cs_n(spi.cs_n),
    .mosi(spi.mosi), .irq(spi.irq), .i_event, .o_state, .o_test_pin_a, .o_test_pin_b,
    .o_test_oe, .o_crystal_pin_p, .o_crystal_pin_n, .o_crystal_oe);

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  // A frame of n bytes each way; the busy poll is bounded so a stuck link ends the run.
  task automatic frame(input int n);
    logic [7:0] s;
    for (int i = 0; i < n; i++) begin
      reg_wr(rsc_pkg::HOST_DATA_REG, tx[i]);
      s = 8'h01;
      for (int k = 0; k < 200 && s[0] === 1'b1; k++) reg_rd(rsc_pkg::HOST_STATUS_REG, s);
      if (s[0] !== 1'b0) begin
        failures++;
        complete_run();
      end
      reg_rd(rsc_pkg::HOST_DATA_REG, rx[i]);
    end
    reg_wr(rsc_pkg::HOST_CTRL_REG, 8'h01);
    repeat (8) @(posedge i_clk_sys);
    #1;
  endtask : frame

  // Memory answers a read strobe one cycle later; events come from the LFSR.
  always @(posedge i_clk_sys) begin
    if (o_mem_wr) mem[o_mem_addr] <= o_mem_wdata;
    if (o_mem_rd) i_mem_rdata <= mem[o_mem_addr];
    i_event <= lfsr_q[3];
  end

  // Every action pulse or memory write takes the oldest expected note.
  always @(posedge i_clk_sys) begin
    if (i_rst_n && (o_act_valid || o_mem_wr)) begin
      check(o_act_valid ? {1'b1, 15'h0, o_act} : {1'b0, o_mem_addr, o_mem_wdata},
        expq.size() > 0 ? expq.pop_front() : 20'hF_FFFF);
    end
  end

  initial begin
    {i_wr, i_rd, i_event, i_mem_rd_unused, i_fw_image_cal, i_fw_cipher, i_fw_coding} = '0;
    {i_addr, i_wdata, i_mem_rdata} = '0;
    {failures, tests_run} = '0;
    lfsr_q = 16'd45357;
    i_rst_n = 1'b0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    tx[0:2] = '{8'h09, 8'h1A, 8'h03};
    frame(3);
    tx[0:2] = '{8'h29, 8'h1A, 8'hFF};
    frame(3);
    check(rx[2], 8'h03);
    for (int p = 0; p < 2; p++) begin
      tx[0:2] = '{8'h19, 8'h39, {p[0], 7'h00}};
      frame(3);
      for (int k = 0; k < 5; k++) begin
        tx[0] = codes[k];
        frame(1);
        check(o_state, sts[k]);
        check({o_test_pin_a, o_test_pin_b, o_test_oe, o_crystal_pin_p, o_crystal_pin_n,
          o_crystal_oe}, p ? {k == 3, k == 2, 4'b1000} : {3'b000, k == 3, k == 2, 1'b1});
      end
    end
    tx[0] = 8'hB5;
    frame(1);
    check(rx[0], {5'h0, rsc_pkg::sleep_state});
    expq.push_back({1'b1, 15'h0, rsc_pkg::ACT_FULL_RESET});
    tx[0] = 8'hC8;
    frame(1);
    check(o_state, rsc_pkg::sleep_state);
    tx[0:2] = '{8'h29, 8'h1A, 8'hFF};
    frame(3);
    check(rx[2], rsc_pkg::RADIO_OPTION_BITS_RST);
    for (int k = 0; k < 16; k++) begin
      {i_fw_image_cal, i_fw_cipher, i_fw_coding} <= acts[k][15:13];
      if (acts[k][12]) expq.push_back({1'b1, 15'h0, acts[k][11:8]});
      tx[0] = acts[k][7:0];
      frame(1);
    end
    {i_fw_image_cal, i_fw_cipher, i_fw_coding} <= 3'b000;
    // A too small divider is clamped, so the rest runs at the fastest legal rate.
    reg_wr(rsc_pkg::HOST_DIV_REG, 8'h02);
    reg_rd(rsc_pkg::HOST_DIV_REG, rx[7]);
    check(rx[7], rsc_pkg::HOST_DIV_MIN);
    for (int k = 0; k < 4; k++) begin
      tx[0:1] = '{{5'h03, sp[k]}, 8'h40};
      for (int j = 0; j < 2; j++) begin
        lfsr_q = lfsr_next(lfsr_q);
        dat[j] = lfsr_q[7:0];
        tx[2 + j] = dat[j];
        expq.push_back({1'b0, sp[k], 8'h40 + 8'(j), dat[j]});
      end
      frame(4);
      tx[0:3] = '{{5'h07, sp[k]}, 8'h40, 8'hFF, 8'hFF};
      frame(4);
      check(rx[2], dat[0]);
      check(rx[3], dat[1]);
    end
    expq.push_back({1'b0, 11'h320, dat[0]});
    expq.push_back({1'b0, 11'h305, dat[1]});
    tx[0:4] = '{8'h0B, 8'h20, dat[0], 8'h05, dat[1]};
    frame(5);
    tx[0:4] = '{8'h2B, 8'h05, 8'hFF, 8'h20, 8'hFF};
    frame(5);
    check({rx[2], rx[4]}, {dat[1], dat[0]});
    check(20'(expq.size()), 20'h0);
    complete_run();
  end
endmodule : radio_spi_command_decoder_tb_top
